// ==== ao_pkg.sv ====
// shared constants and types for the adc output formatter
// What this block does
// RULE_01: output word is 10 bits, bit0 lsb
// RULE_02: each bit drives true and inverse lines
// RULE_03: over-range drives true flag line high
// RULE_04: over-range drives complement flag line low
// RULE_05: format 0 two's complement, 1 offset
// RULE_06: unconnected format select means two's complement
// RULE_07: forwarded differential copy of converter clock; at half rate the code forwards half the converter clock
// RULE_08: divider select 0 half, 1 full rate
// RULE_09: receiver captures on next forwarded rising edge
// RULE_10: flag updates with its data word
package ao_pkg;
  localparam int          WORD_W      = 10;        // sample word width
  localparam int          PCLK_MHZ    = 40;        // bus clock rate
  localparam int          ADDR_W      = 12;        // apb address width
  // register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;   // format and rate override
  localparam logic [11:0] OFS_STATUS  = 12'h004;   // sticky events, read clears
  localparam logic [11:0] OFS_MASK    = 12'h008;   // interrupt mask
  localparam logic [11:0] OFS_LAST    = 12'h00C;   // last launched word
  // control field positions
  localparam int          CTRL_FMT_OV = 0;         // software owns format
  localparam int          CTRL_FMT    = 1;         // software format value
  localparam int          CTRL_RATE_OV = 2;        // software owns rate select
  localparam int          CTRL_RATE   = 3;         // software rate value
  // status and mask field positions
  localparam int          EV_OVER     = 0;         // over-range sample seen
  localparam int          EV_LAUNCH   = 1;         // word launched to pins
  localparam int          EV_W        = 2;         // number of events
  // last-word field positions
  localparam int          LAST_OVER   = 10;        // flag beside the word
  localparam int          LAST_FMT    = 16;        // effective format
  localparam int          LAST_RATE   = 17;        // effective rate select
  // reset values
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam logic [1:0]  PHASE_RST   = 2'h0;
  // one word with its range flag, moved as a unit
  typedef struct packed {
    logic                over;
    logic [WORD_W-1:0]   code;
  } ao_word_t;
  // apb answer sequencing
  typedef enum logic [2:0] {
    AO_IDLE = 3'b001,
    AO_WAIT = 3'b010,
    AO_ANS  = 3'b100
  } ao_apb_st_t;
endpackage

// ==== ao_diff_reg.sv ====
// registered differential output pairs, true and complement
`timescale 1ns/10ps
module ao_diff_reg
  import ao_pkg::*;
#(
  parameter int W = 11
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q_true,
  output logic [W-1:0]      q_comp
);
  initial begin
    if (W < 1) $error("ao_diff_reg width must be positive");
  end

  logic [W-1:0] next_true;   // value for the true lines
  logic [W-1:0] next_comp;   // value for the complement lines

  // one pair per bit; complement is the inverse of the next true value
  genvar i;
  for (i = 0; i < W; i++) begin : g_pair
    always_comb begin
      next_true[i] = load ? d[i] : q_true[i];
      next_comp[i] = ~next_true[i];  // RULE_02
    end
  end

  // complement resets high so the pair stays opposite even in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_true <= '0;
      q_comp <= '1;
    end else begin
      q_true <= next_true;
      q_comp <= next_comp;
    end
  end

  pair_opposite_a: assert property (@(posedge pclk) disable iff (!presetn) (q_comp == ~q_true)) // RULE_02
    else $error("differential pair not complementary");
endmodule // ao_diff_reg

// ==== ao_rate_gen.sv ====
// converter sample enable, output update enable and forwarded clock level
`timescale 1ns/10ps
module ao_rate_gen
  import ao_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic full_rate,
  output logic      sample_en,
  output logic      update_en,
  output logic      fwd_next
);
  logic [1:0] phase;       // free running divider phase
  logic [1:0] next_phase;

  // converter clock is pclk/2: a sample is taken when phase bit 0 is high
  always_comb begin
    next_phase = phase + 2'h1;
    sample_en  = phase[0];
    // full rate updates every sample, half rate every second one
    update_en  = full_rate ? phase[0] : (phase == 2'h3);  // RULE_08
    // forwarded clock falls at launch and rises mid-word
    fwd_next   = full_rate ? ~phase[0] : (phase[0] ^ phase[1]);  // RULE_07 RULE_09
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase <= PHASE_RST;
    else          phase <= next_phase;
  end

  sample_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
    sample_en |=> !sample_en ##1 sample_en) // RULE_07
    else $error("converter sample enable not every second cycle");
  half_rate_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update_en && !full_rate) ##1 !full_rate[*3] |-> !$past(update_en) && !$past(update_en, 2)) // RULE_08
    else $error("half rate update came too soon");
endmodule // ao_rate_gen

// ==== ao_formatter.sv ====
// adc output formatter top: sample formatting, differential pins, apb registers
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module ao_formatter
  import ao_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  // converter core side, raw code is offset binary
  input  wire logic [WORD_W-1:0] core_code,
  input  wire logic              core_over,
  // strap pins, pull-down makes an open pin read 0
  input  wire logic              format_select,
  input  wire logic              half_rate_select,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // differential sample pins
  output logic [WORD_W-1:0]      sample_bit_true,
  output logic [WORD_W-1:0]      sample_bit_comp,
  output logic                   range_exceeded_true,
  output logic                   range_exceeded_comp,
  output logic                   fwd_clock_true,
  output logic                   fwd_clock_comp
);
  // ------------------------------------------------------------ registers
  logic [3:0]      ctrl;           // override bits
  logic [3:0]      next_ctrl;
  logic [EV_W-1:0] status;         // sticky events
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] mask;           // interrupt enables
  logic [EV_W-1:0] next_mask;
  logic            next_irq;
  ao_apb_st_t      st;             // apb answer state
  ao_apb_st_t      next_st;
  logic [31:0]     next_prdata;
  logic            next_pslverr;
  ao_word_t        last_word;      // copy of what the pins show
  ao_word_t        next_last;

  // ------------------------------------------------------------ effective selects
  logic fmt_offset;                // 1 selects offset binary
  logic full_rate;                 // 1 selects full update rate
  logic sample_en;
  logic update_en;
  logic fwd_next;
  ao_word_t launch_word;           // formatted word headed for the pins
  logic [EV_W-1:0] events;

  // an open format pin reads 0 through its pull-down, so two's complement
  assign fmt_offset = ctrl[CTRL_FMT_OV] ? ctrl[CTRL_FMT] : format_select;  // RULE_06
  assign full_rate  = ctrl[CTRL_RATE_OV] ? ctrl[CTRL_RATE] : half_rate_select;

  ao_rate_gen u_rate (
    .pclk      (pclk),
    .presetn   (presetn),
    .full_rate (full_rate),
    .sample_en (sample_en),
    .update_en (update_en),
    .fwd_next  (fwd_next)
  );

  // formatting: two's complement is offset binary with the msb flipped
  always_comb begin
    launch_word.over = core_over;  // RULE_03 RULE_04
    launch_word.code = core_code;  // RULE_01
    if (!fmt_offset) begin
      launch_word.code[WORD_W-1] = ~core_code[WORD_W-1];  // RULE_05
    end
  end

  // word and range flag load together, one register stage, same edge
  ao_diff_reg #(.W(WORD_W + 1)) u_data (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (update_en),  // RULE_10
    .d       (launch_word),
    .q_true  ({range_exceeded_true, sample_bit_true}),
    .q_comp  ({range_exceeded_comp, sample_bit_comp})
  );

  // forwarded clock pair, registered beside the data so skew stays one flop
  ao_diff_reg #(.W(1)) u_fwd (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (1'b1),
    .d       (fwd_next),  // RULE_07
    .q_true  (fwd_clock_true),
    .q_comp  (fwd_clock_comp)
  );

  // ------------------------------------------------------------ apb decode
  logic acc_done;                  // edge at which the master sees pready
  logic rd_status;
  assign acc_done  = psel && penable && pready;
  assign rd_status = acc_done && !pwrite && (paddr == OFS_STATUS);

  // one wait state: the answer is computed then registered with pready
  always_comb begin
    next_st      = st;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    unique case (st)
      AO_IDLE: begin
        // a setup cycle moves on into the wait state
        if (psel && !penable) begin
          next_st = AO_WAIT;
        end
      end
      AO_WAIT: begin
        next_st      = AO_ANS;
        next_pslverr = 1'b0;
        next_prdata  = '0;
        unique case (paddr)
          OFS_CTRL: begin
            next_prdata[3:0] = ctrl;
          end
          OFS_STATUS: begin
            next_prdata[EV_W-1:0] = status;
          end
          OFS_MASK: begin
            next_prdata[EV_W-1:0] = mask;
          end
          OFS_LAST: begin
            next_prdata[WORD_W:0]  = last_word;
            next_prdata[LAST_FMT]  = fmt_offset;
            next_prdata[LAST_RATE] = full_rate;
          end
          default: begin
            // unmapped address: error answer, reads zero
            next_pslverr = 1'b1;
          end
        endcase
        if (pwrite) begin
          next_prdata = '0;
        end
      end
      AO_ANS: begin
        // the master releases after this edge; a new setup may follow at once
        next_st      = AO_IDLE;
        next_prdata  = '0;
        next_pslverr = 1'b0;
      end
      default: begin
        next_st = AO_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st      <= AO_IDLE;
      prdata  <= '0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      st      <= next_st;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
      pready  <= (next_st == AO_ANS);
    end
  end

  // ------------------------------------------------------------ control, mask, status
  // events: an over-range sample, and a launch of a word to the pins
  always_comb begin
    events            = '0;
    events[EV_OVER]   = sample_en && core_over;
    events[EV_LAUNCH] = update_en;
  end

  // writes land only on the edge that completes the access
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    if (acc_done && pwrite && !pslverr) begin
      if (paddr == OFS_CTRL) begin
        next_ctrl = pwdata[3:0];
      end
      if (paddr == OFS_MASK) begin
        next_mask = pwdata[EV_W-1:0];
      end
    end
    // read clears, but an event in the same cycle is kept
    next_status = (rd_status ? '0 : status) | events;
    next_irq    = |(next_status & next_mask);
    next_last   = update_en ? launch_word : last_word;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= CTRL_RST;
      mask      <= MASK_RST;
      status    <= '0;
      irq       <= 1'b0;
      last_word <= '0;
    end else begin
      ctrl      <= next_ctrl;
      mask      <= next_mask;
      status    <= next_status;
      irq       <= next_irq;
      last_word <= next_last;
    end
  end

  // ------------------------------------------------------------ checks
  word_follows_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    update_en |=> sample_bit_true[WORD_W-2:0] == $past(core_code[WORD_W-2:0])) // RULE_01
    else $error("launched low bits differ from converter code");
  twos_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update_en && !fmt_offset) |=> sample_bit_true[WORD_W-1] != $past(core_code[WORD_W-1])) // RULE_05
    else $error("two's complement msb not inverted");
  offset_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update_en && fmt_offset) |=> sample_bit_true[WORD_W-1] == $past(core_code[WORD_W-1])) // RULE_05
    else $error("offset binary msb altered");
  open_pin_twos_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl[CTRL_FMT_OV] && !format_select) |-> !fmt_offset) // RULE_06
    else $error("low format pin did not give two's complement");
  over_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update_en && core_over) |=> range_exceeded_true && !range_exceeded_comp) // RULE_03 RULE_04
    else $error("over-range flag pair not raised");
  flag_with_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(range_exceeded_true) |-> $past(update_en)) // RULE_10
    else $error("range flag moved without a word launch");
  fwd_rise_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    (update_en && full_rate) ##1 full_rate |-> !fwd_clock_true ##1 fwd_clock_true) // RULE_07 RULE_09
    else $error("forwarded clock did not rise one cycle after launch");
  ans_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && st == AO_IDLE) |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  status_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_status && update_en) |=> status[EV_LAUNCH])
    else $error("launch event lost under read clear");
endmodule // ao_formatter

// ==== ao_rx_model.sv ====
// receiver model: latches word and flag on the forwarded clock
`timescale 1ns/10ps
module ao_rx_model
  import ao_pkg::*;
(
  input  wire logic              fwd_clock_true,
  input  wire logic [WORD_W-1:0] sample_bit_true,
  input  wire logic              range_exceeded_true,
  output ao_word_t               cap_word,
  output int                     cap_cnt,
  output time                    cap_gap
);
  time last_t;  // time of the previous capture
  initial begin
    cap_word = '0;
    cap_cnt  = 0;
    cap_gap  = 0;
    last_t   = 0;
  end
  // capture on the rising forwarded edge; flag rides with its word
  always @(posedge fwd_clock_true) begin
    cap_word <= '{over: range_exceeded_true, code: sample_bit_true};
    cap_gap  <= $time - last_t;  // spacing gives the update rate
    last_t   <= $time;
    cap_cnt  <= cap_cnt + 1;
  end
endmodule  // ao_rx_model

// ==== ao_formatter_tb.sv ====
// self-checking testbench for the adc output formatter
`timescale 1ns/10ps
module ao_formatter_tb
  import ao_pkg::*;
;
  logic              pclk, presetn, format_select, half_rate_select, core_over;
  logic              psel, penable, pwrite, pready, pslverr, irq, err;
  logic [WORD_W-1:0] core_code, sample_bit_true, sample_bit_comp;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              range_exceeded_true, range_exceeded_comp, fwd_clock_true, fwd_clock_comp;
  ao_word_t          cap_word;  // word seen by the receiver
  int                cap_cnt, fail_count, compares;
  time               cap_gap;
  ao_formatter i_dut (.pclk(pclk), .presetn(presetn), .core_code(core_code), .core_over(core_over),
    .format_select(format_select), .half_rate_select(half_rate_select), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sample_bit_true(sample_bit_true), .sample_bit_comp(sample_bit_comp),
    .range_exceeded_true(range_exceeded_true), .range_exceeded_comp(range_exceeded_comp),
    .fwd_clock_true(fwd_clock_true), .fwd_clock_comp(fwd_clock_comp));
  ao_rx_model i_rx (.fwd_clock_true(fwd_clock_true), .sample_bit_true(sample_bit_true),
    .range_exceeded_true(range_exceeded_true), .cap_word(cap_word), .cap_cnt(cap_cnt), .cap_gap(cap_gap));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // compare and count
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  // one apb transfer; waits for pready with a bound, never assumes latency
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // let n receiver captures pass; bounded so a dead link is reported
  task wait_caps(input int n);
    int c;
    int target;
    target = cap_cnt + n;
    for (c = 0; c < 200 && cap_cnt < target; c++) @(posedge pclk);
    if (cap_cnt < target) chk("capture", 32'h1, 32'h0);
  endtask
  // idle pin levels and register reset values
  task t_reset;
    chk("true pins", 32'h0, {21'h0, range_exceeded_true, sample_bit_true});
    chk("comp pins", 32'h7FF, {21'h0, range_exceeded_comp, sample_bit_comp});
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, OFS_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    $display("test reset done");
  endtask
  // both formats at the two end codes and one mid code, full rate
  task t_format;
    logic [WORD_W-1:0] codes [3];
    logic [WORD_W-1:0] exp;
    codes = '{10'h000, 10'h3FF, 10'h2A5};
    half_rate_select <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 3; i++) begin
        format_select <= f[0];  // 0 also stands for the open pin
        core_code     <= codes[i];
        wait_caps(3);
        exp = f[0] ? codes[i] : {~codes[i][9], codes[i][8:0]};
        chk("word", {22'h0, exp}, {22'h0, cap_word.code});
        chk("word comp", {22'h0, ~sample_bit_true}, {22'h0, sample_bit_comp});
      end
    end
    $display("test format done");
  endtask
  // range flag set and cleared together with its word
  task t_over;
    core_over <= 1'b1;
    core_code <= 10'h3FF;
    wait_caps(3);
    chk("flag", 32'h1, {31'h0, cap_word.over});
    chk("flag comp", 32'h0, {31'h0, range_exceeded_comp});
    core_over <= 1'b0;
    wait_caps(3);
    chk("flag clear", 32'h1, {31'h0, range_exceeded_comp});
    chk("flag word", 32'h0, {31'h0, cap_word.over});
    $display("test over done");
  endtask
  // update spacing for each divider setting; forwarded pair stays opposite
  task t_rate;
    for (int s = 0; s < 2; s++) begin
      half_rate_select <= s[0];
      wait_caps(3);
      chk("gap", (s == 0) ? 32'd100 : 32'd50, 32'(cap_gap));
      chk("fwd comp", {31'h0, ~fwd_clock_true}, {31'h0, fwd_clock_comp});
    end
    $display("test rate done");
  endtask
  // interrupt masked, raised, cleared; format override; unmapped access
  task t_regs;
    core_over <= 1'b1;
    wait_caps(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    core_over <= 1'b0;
    wait_caps(3);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h3, rd);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_CTRL, 32'h3);
    format_select <= 1'b0;
    core_code     <= 10'h155;
    wait_caps(3);
    apb(1'b0, OFS_LAST, 32'h0);
    chk("last", 32'h30155, rd);
    // rate override: software forces half rate over the full-rate strap
    apb(1'b1, OFS_CTRL, 32'h4);
    wait_caps(3);
    chk("override gap", 32'd100, 32'(cap_gap));
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask
  // verdict and end of run
  task wrap_up;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 25);
    fail_count++;
    wrap_up;
  end
  // main sequence
  initial begin
    fail_count = 0; compares = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    core_code = '0; core_over = 1'b0; format_select = 1'b0; half_rate_select = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_format;
    t_over;
    t_rate;
    t_regs;
    wrap_up;
  end
endmodule  // ao_formatter_tb
